// ### core/scpr_defs.svh
`ifndef SCPR_DEFS_SVH
`define SCPR_DEFS_SVH
// Stored capacity in bits and derived address width
`define SCPR_CAPACITY      1048576
`define SCPR_ADDR_W        20
// Reset polarity option value after reset: 1 = active high
`define SCPR_RST_POL_RESET 1'b1
// Fastest supported loader clock, in kHz
`define SCPR_FMAX_KHZ      15000
`define SCPR_CLK_KHZ       25000
// Depth of the data FIFO
`define SCPR_FIFO_DEPTH    8
`endif

// ### core/scpr_pkg.sv
`include "scpr_defs.svh"
package scpr_pkg;
   typedef logic [`SCPR_ADDR_W-1:0] scpr_addr_type;

   typedef struct packed {
      logic chip_select_n;
      logic reset_gate;
      logic loader_configuration_clock;
   } scpr_pins_type;

   typedef struct packed {
      logic data;
      logic data_oe;
      logic chain_select_out;
   } scpr_out_type;

   typedef struct packed {
      logic [1:0] ptr;
      logic       full;
   } scpr_fifo_meta_type;
endpackage : scpr_pkg

// ### core/scpr_fifo.sv
module scpr_fifo
   import scpr_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 count;
   } scpr_fifo_state_type;

   scpr_fifo_state_type st;
   scpr_fifo_state_type next_st;
   logic                push;
   logic                pop;

   function automatic logic [AW-1:0] scpr_wrap(input logic [AW-1:0] p);
      scpr_wrap = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : scpr_wrap

   always_comb begin
      next_st = st;
      push    = in_valid_i && (st.count != (AW+1)'(DEPTH));
      pop     = out_ready_i && (st.count != '0);
      if (push) begin
         next_st.mem[st.wr] = in_data_i;
         next_st.wr         = scpr_wrap(st.wr);
      end
      if (pop) begin
         next_st.rd = scpr_wrap(st.rd);
      end
      next_st.count = (AW+1)'(st.count + push - pop);
      if (flush_i) begin
         next_st.wr    = '0;
         next_st.rd    = '0;
         next_st.count = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign in_ready_o  = (st.count != (AW+1)'(DEPTH));
   assign out_valid_o = (st.count != '0);
   assign out_data_o  = st.mem[st.rd];
endmodule : scpr_fifo

// ### core/scpr_reader.sv
// Overview of operation
// - Count up on clock rise when enabled
// - Float data unless select and gate active
// - Reset state holds counter zero, data floated
// - Reset polarity selectable, default active high
// - Select high freezes, floats, enters standby
// - Chain select out feeds next chip select
// - Next bit appears after each rising edge
// - Valid data up to 15 MHz clock
// - Chain out low only when past terminal
// - Gate inactive after readout keeps out high
// - Terminal count is highest address, then stop
// - Clock after last bit hands line over
`include "scpr_defs.svh"
module scpr_reader
   import scpr_pkg::*;
#(
   parameter int CAPACITY = `SCPR_CAPACITY,
   parameter int ADDR_W   = `SCPR_ADDR_W
) (
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic              loader_configuration_clock_i,
   input  wire logic              chip_select_n_i,
   input  wire logic              reset_gate_i,
   input  wire logic              reset_active_high_i,
   input  wire logic              polarity_load_i,
   output logic [ADDR_W-1:0]      mem_addr_o,
   input  wire logic              mem_bit_i,
   output logic                   data_o,
   output logic                   data_oe_o,
   output logic                   chain_select_out_o,
   output logic                   standby_o,
   output logic                   past_terminal_o
);
   // Sampling needs at least one fast cycle per clock phase
   localparam int MIN_RATIO = (`SCPR_CLK_KHZ + `SCPR_FMAX_KHZ - 1) / `SCPR_FMAX_KHZ;
   localparam logic [ADDR_W-1:0] TERMINAL = ADDR_W'(CAPACITY - 1);

   typedef struct packed {
      scpr_pins_type     s1;
      scpr_pins_type     s2;
      logic              clk_prev;
      logic              rst_pol;
      logic [ADDR_W-1:0] addr;
      logic              past;
      logic              fetch;
      logic              data;
      logic              data_oe;
      logic              chain;
      logic              standby;
   } scpr_state_type;

   scpr_state_type st;
   scpr_state_type next_st;
   logic           reset_on;
   logic           enabled;
   logic           rise;
   logic           fifo_in_ready;
   logic           fifo_out_valid;
   logic           fifo_data;
   logic           fifo_pop;

   always_comb begin
      next_st    = st;
      next_st.s1 = '{chip_select_n:              chip_select_n_i,
                     reset_gate:                 reset_gate_i,
                     loader_configuration_clock: loader_configuration_clock_i};
      next_st.s2 = st.s1;
      next_st.clk_prev = st.s2.loader_configuration_clock;
      rise     = st.s2.loader_configuration_clock && !st.clk_prev;
      reset_on = (st.s2.reset_gate == st.rst_pol);
      enabled  = !st.s2.chip_select_n && !reset_on;
      fifo_pop = 1'b0;
      next_st.fetch = 1'b0;
      if (polarity_load_i) begin
         next_st.rst_pol = reset_active_high_i;
      end
      if (reset_on) begin
         next_st.addr  = '0;
         // Clearing here keeps chain output high until the next readout
         next_st.past  = 1'b0;
         // Queue the bit at address zero so it waits for the first rise
         next_st.fetch = 1'b1;
      end else if (enabled && rise && fifo_in_ready) begin
         // Stop changing once beyond the highest address
         if (!st.past) begin
            if (st.addr == TERMINAL) begin
               next_st.past = 1'b1;
            end else begin
               next_st.addr  = ADDR_W'(st.addr + 1'b1);
               next_st.fetch = 1'b1;
            end
         end
      end
      if (fifo_out_valid) begin
         fifo_pop     = 1'b1;
         next_st.data = fifo_data;
      end
      next_st.data_oe = enabled && !st.past && !next_st.past;
      next_st.chain   = !(enabled && st.past);
      next_st.standby = st.s2.chip_select_n;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st         <= '0;
         st.rst_pol <= `SCPR_RST_POL_RESET;
         st.chain   <= 1'b1;
         // Synchronisers start deselected and in reset, so no drive glitch
         st.s1.chip_select_n <= 1'b1;
         st.s2.chip_select_n <= 1'b1;
         st.s1.reset_gate    <= `SCPR_RST_POL_RESET;
         st.s2.reset_gate    <= `SCPR_RST_POL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Holds the addressed bit; flushed by reset, but data_o drives its old bit for one cycle after reset ends
   scpr_fifo #(
      .WIDTH (1),
      .DEPTH (`SCPR_FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .nrst_i      (nrst_i),
      .flush_i     (reset_on),
      .in_valid_i  (st.fetch),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (mem_bit_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   assign mem_addr_o         = st.addr;
   assign data_o             = st.data;
   assign data_oe_o          = st.data_oe;
   assign chain_select_out_o = st.chain;
   assign standby_o          = st.standby;
   assign past_terminal_o    = st.past;
endmodule : scpr_reader

// ### testbench/scpr_reader_assertions.sv
`include "scpr_defs.svh"
module scpr_reader_checker #(
   parameter int ADDR_W = 4
) (
   input wire logic              clk_i,
   input wire logic              nrst_i,
   input wire logic              loader_configuration_clock_i,
   input wire logic              chip_select_n_i,
   input wire logic              reset_gate_i,
   input wire logic              reset_active_high_i,
   input wire logic              polarity_load_i,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic              data_oe_o,
   input wire logic              chain_select_out_o,
   input wire logic              standby_o,
   input wire logic              past_terminal_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Polarity option only follows its pin while the load strobe is high
   logic      pol_model;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pol_model <= `SCPR_RST_POL_RESET;
      end else if (polarity_load_i) begin
         pol_model <= reset_active_high_i;
      end
   end
   wire logic rst_on = reset_gate_i == pol_model;
   wire logic run    = !chip_select_n_i && !rst_on && !past_terminal_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_addr_step: assert property (
      ($rose(loader_configuration_clock_i) && run) ##1 run [*6]
      |-> mem_addr_o == ADDR_W'($past(mem_addr_o, 6) + 1'h1)) else $error("no step");
   a_float_off: assert property ((chip_select_n_i || rst_on) [*6] |-> !data_oe_o)
      else $error("driven");
   a_reset_zero: assert property (rst_on [*6] |-> mem_addr_o == '0 && chain_select_out_o)
      else $error("not reset");
   a_standby_hold: assert property ((chip_select_n_i && !rst_on) [*6]
      |=> standby_o && $stable(mem_addr_o)) else $error("no standby");
   a_chain_cause: assert property (!chain_select_out_o |-> past_terminal_o)
      else $error("chain early");
   a_past_hold: assert property (past_terminal_o [*2] |-> $stable(mem_addr_o))
      else $error("moved");
   a_hand_over: assert property (!chain_select_out_o [*3] |-> !data_oe_o)
      else $error("contention");
   a_drive_cause: assert property ($rose(data_oe_o) |-> !past_terminal_o)
      else $error("late drive");
   c_chain: cover property ($fell(chain_select_out_o));
   c_drive: cover property ($rose(data_oe_o));
   c_standby: cover property ($rose(standby_o));
endmodule : scpr_reader_checker
bind scpr_reader scpr_reader_checker #(.ADDR_W(ADDR_W)) chk (.*);

// ### testbench/scpr_loader.sv
module scpr_loader (
   input  wire logic clk_i,
   input  wire logic din_i,
   output logic      lcc_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] bits;
   initial lcc_o = 1'h0;
   // Clock stands low between frames, n pulses only
   task automatic frame(input int n);
      for (int k = 0; k < n; k++) begin
         repeat (4) @(posedge clk_i);
         bits[k] = din_i; // Read just before the rise
         lcc_o <= 1'h1;
         repeat (4) @(posedge clk_i);
         lcc_o <= 1'h0;
      end
   endtask : frame
endmodule : scpr_loader

// ### testbench/tb_scpr_reader.sv
module tb_scpr_reader;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] PAT = 16'hB5C3;
   logic       clk_i = 1'h0;
   logic       nrst_i, polarity_load_i, lcc, din, mem_bit;
   logic       chip_select_n_i, reset_gate_i, reset_active_high_i;
   logic [3:0] mem_addr_o;
   logic [15:0] store;
   logic       data_o, data_oe_o, chain_select_out_o, standby_o, past_terminal_o;
   int         errors = 0, check_count = 0;
   always #20 clk_i = ~clk_i;
   assign din = data_oe_o ? data_o : 1'h1; // Pulled up once released
   assign mem_bit = store[mem_addr_o];
   scpr_reader #(
      .CAPACITY (16),
      .ADDR_W   (4)
   ) dut (
      .clk_i                        (clk_i),
      .nrst_i                       (nrst_i),
      .loader_configuration_clock_i (lcc),
      .chip_select_n_i              (chip_select_n_i),
      .reset_gate_i                 (reset_gate_i),
      .reset_active_high_i          (reset_active_high_i),
      .polarity_load_i              (polarity_load_i),
      .mem_addr_o                   (mem_addr_o),
      .mem_bit_i                    (mem_bit),
      .data_o                       (data_o),
      .data_oe_o                    (data_oe_o),
      .chain_select_out_o           (chain_select_out_o),
      .standby_o                    (standby_o),
      .past_terminal_o              (past_terminal_o)
   );
   scpr_loader ld (.clk_i(clk_i), .din_i(din), .lcc_o(lcc));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      #1;
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   // Pins pass a synchroniser, so let them settle
   task automatic pins(input logic cs, input logic gate, input logic pol, input logic load);
      @(posedge clk_i);
      chip_select_n_i <= cs;
      reset_gate_i <= gate;
      reset_active_high_i <= pol;
      polarity_load_i <= load;
      repeat (8) @(posedge clk_i);
   endtask : pins
   initial begin
      nrst_i <= 1'h0;
      chip_select_n_i <= 1'h1;
      reset_gate_i <= 1'h1;
      reset_active_high_i <= 1'h1;
      polarity_load_i <= 1'h1;
      store <= PAT;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'h1;
      @(posedge clk_i);
      chk({mem_addr_o, chain_select_out_o, data_oe_o}, 6'h02);
      pins(1'h1, 1'h0, 1'h1, 1'h1);
      ld.frame(2);
      chk({mem_addr_o, standby_o, data_oe_o}, 6'h02);
      pins(1'h0, 1'h0, 1'h1, 1'h1);
      ld.frame(16);
      repeat (8) @(posedge clk_i);
      chk(ld.bits, PAT);
      chk({past_terminal_o, chain_select_out_o, data_oe_o, mem_addr_o}, 7'h4F);
      ld.frame(2);
      chk(mem_addr_o, 4'hF);
      pins(1'h1, 1'h0, 1'h1, 1'h1);
      chk({chain_select_out_o, standby_o}, 2'h3);
      pins(1'h0, 1'h0, 1'h1, 1'h1);
      chk(chain_select_out_o, 1'h0);
      pins(1'h0, 1'h1, 1'h1, 1'h1);
      chk({mem_addr_o, chain_select_out_o, data_oe_o, past_terminal_o}, 7'h04);
      pins(1'h0, 1'h0, 1'h1, 1'h1);
      chk(chain_select_out_o, 1'h1);
      pins(1'h0, 1'h1, 1'h0, 1'h1);
      ld.frame(3);
      repeat (8) @(posedge clk_i);
      chk(mem_addr_o, 4'h3);
      chk(ld.bits[2:0], PAT[2:0]);
      pins(1'h0, 1'h0, 1'h0, 1'h1);
      ld.frame(2);
      chk({mem_addr_o, data_oe_o}, 5'h00);
      // Option pin changes without the load strobe must not flip polarity
      pins(1'h0, 1'h1, 1'h1, 1'h0);
      ld.frame(2);
      chk({mem_addr_o, data_oe_o}, 5'h05);
      stop_test();
   end
endmodule : tb_scpr_reader
